// ==== rtl/rsq_pkg.sv ====
// Purpose: shared constants and types of the rail sequence and fault controller
// Assumes: one 10 MHz core clock
// Notes: register indices sit on the host-side register port
`default_nettype none
package rsq_pkg;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int EN_DELAY_NS = 450000;
  localparam int EN_DELAY_CYC = (EN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam logic [12:0] DOWN_STEP_MS = 13'h0064;
  localparam logic [12:0] OFF_TIME_MS = 13'h03e8;
  localparam logic [12:0] PWR_TIMER_MS = 13'h1388;
  localparam logic [12:0] RISE_TIMEOUT_MS = 13'h1388;
  // =====================================================
  // register map
  localparam logic [2:0] ADDR_MAIN_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DOWN_A = 3'h1;
  localparam logic [2:0] ADDR_DOWN_B = 3'h2;
  localparam logic [2:0] ADDR_RAIL_EN = 3'h3;
  localparam logic [2:0] ADDR_KEEP = 3'h4;
  localparam logic [2:0] ADDR_EVENT = 3'h5;
  localparam logic [2:0] ADDR_RAIL_VALID = 3'h6;
  localparam int CTRL_HEAT_LSB = 0;
  localparam int CTRL_SUPPLY_LSB = 2;
  localparam int CTRL_SW_MODE = 5;
  localparam int CTRL_HOLD = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DOWN_RST = 8'h00;
  localparam logic [6:0] RAIL_RST = 7'h00;
  localparam int EVT_SUPPLY_WARN = 0;
  localparam int EVT_SUPPLY_STBY = 1;
  localparam int EVT_HEAT_WARN = 2;
  localparam int EVT_HEAT_STBY = 3;
  localparam int EVT_RAIL_LOW = 4;
  localparam logic [4:0] EVT_RST = 5'h00;
  localparam int NUM_RAILS = 7;
  // =====================================================
  // types
  typedef enum logic [2:0] {
    MODE_POR, MODE_PWR_TIMER, MODE_ON, MODE_OFF_STBY, MODE_OFF_HRST, MODE_STANDBY
  } rsq_mode_type;
  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } rsq_reg_req_type;
  typedef struct packed {
    rsq_mode_type mode;
    logic [7:0] ctrl;
    logic [7:0] down_a;
    logic [7:0] down_b;
    logic [6:0] rail_en;
    logic [6:0] keep;
    logic [4:0] evt;
    logic [7:0] rdata;
    logic [15:0] ms_div;
    logic [12:0] tmr;
    logic [12:0] rise_cnt;
    logic rise_seen;
    logic inhibit;
    logic heat_flt;
    logic [6:0] was_on;
    logic [6:0] en_out;
  } rsq_main_state_type;
  typedef struct packed {
    logic [15:0] cnt;
    logic out;
  } rsq_dly_state_type;
endpackage
`default_nettype wire

// ==== rtl/rsq_pin_delay.sv ====
// Purpose: fixed delay from an enable pin rising to the internal enable
// Assumes: pin synchronous to clk_sys
// Notes: pin low drops the output at once
`default_nettype none
module rsq_pin_delay #(
  parameter int DLY_CYC = rsq_pkg::EN_DELAY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  output logic dly_out
);
  localparam logic [15:0] DLY_LAST = 16'(DLY_CYC - 1);
  localparam logic [15:0] DLY_FULL = 16'(DLY_CYC);
  rsq_pkg::rsq_dly_state_type s_reg;
  rsq_pkg::rsq_dly_state_type s_next;

  initial begin
    if (DLY_CYC < 1 || DLY_CYC > 65535) $error("pin delay out of range");
  end

  always_comb begin
    s_next = s_reg;
    if (!pin) begin
      s_next.cnt = 16'h0000;
      s_next.out = 1'b0;
    end else if (s_reg.cnt != DLY_FULL) begin
      s_next.cnt = s_reg.cnt + 16'h0001;
      s_next.out = (s_reg.cnt == DLY_LAST);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dly_out = s_reg.out;

  pin_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(s_reg.out) |-> $past(pin) && s_reg.cnt == DLY_FULL)
    else $error("enable passed before its delay");
endmodule
`default_nettype wire

// ==== rtl/rsq_seq_ctrl.sv ====
// Purpose: rail enable, power-down ordering and supply/heat fault control
// Assumes: pins and comparator flags synchronous to clk_sys
// Notes: rails 0..3 are switcher_one..four, 4..6 linear_reg_two..four
`default_nettype none
module rsq_seq_ctrl #(
  parameter int EN_DLY_CYC = rsq_pkg::EN_DELAY_CYC,
  parameter int MS_CYC = rsq_pkg::MS_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_hold_in,
  input wire logic hrst_req_in,
  input wire logic [6:0] en_pin_in,
  input wire logic [6:0] rail_ok_in,
  input wire logic supply_rise_ok_in,
  input wire logic supply_low_fault,
  input wire logic supply_warn_in,
  input wire logic die_heat_fault,
  input wire logic die_cool_in,
  input wire logic heat_warn_in,
  input wire rsq_pkg::rsq_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic [6:0] rail_en_out,
  output logic wake_out,
  output logic attn_req_n,
  output logic rails_valid_pin_out,
  output logic rails_valid_pin_oe,
  output logic [2:0] supply_warn_code,
  output logic [1:0] heat_warn_code
);
  localparam logic [15:0] MS_LAST = 16'(MS_CYC - 1);
  rsq_pkg::rsq_main_state_type s_reg;
  rsq_pkg::rsq_main_state_type s_next;
  logic [6:0] pin_dly;
  logic [6:0] src;
  logic [6:0] off_hold;
  logic [6:0] next_en;
  logic [6:0] low_rail;
  logic tick;
  logic run;
  logic in_off;
  logic hold_req;
  logic fault;

  initial begin
    if (MS_CYC < 2 || MS_CYC > 65535) $error("ms divider out of range");
  end

  // =====================================================
  // helpers
  function automatic logic [1:0] down_code(input logic [7:0] a, input logic [7:0] b, input int i);
    down_code = (i < 4) ? a[2*i +: 2] : b[2*(i-4) +: 2];
  endfunction

  function automatic logic [12:0] hold_ms(input logic [1:0] code);
    hold_ms = 13'(code * rsq_pkg::DOWN_STEP_MS);
  endfunction

  // =====================================================
  // enable pin delays
  genvar g;
  generate
    for (g = 0; g < rsq_pkg::NUM_RAILS; g++) begin : g_pin
      rsq_pin_delay #(.DLY_CYC(EN_DLY_CYC)) u_dly (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(en_pin_in[g]),
        .dly_out(pin_dly[g])
      );
    end
  endgenerate

  // =====================================================
  // enable composition
  assign tick = (s_reg.ms_div == MS_LAST);
  assign in_off = (s_reg.mode == rsq_pkg::MODE_OFF_STBY) || (s_reg.mode == rsq_pkg::MODE_OFF_HRST);
  assign run = ((s_reg.mode == rsq_pkg::MODE_PWR_TIMER) || (s_reg.mode == rsq_pkg::MODE_ON)) && !s_reg.inhibit;
  assign hold_req = power_hold_in || s_reg.ctrl[rsq_pkg::CTRL_HOLD];
  assign fault = (supply_low_fault && s_reg.rise_seen) || s_reg.heat_flt;
  assign src = s_reg.ctrl[rsq_pkg::CTRL_SW_MODE] ? s_reg.rail_en : pin_dly;

  always_comb begin
    for (int i = 0; i < rsq_pkg::NUM_RAILS; i++) begin
      off_hold[i] = in_off && !s_reg.inhibit && s_reg.was_on[i] &&
        (s_reg.tmr < hold_ms(down_code(s_reg.down_a, s_reg.down_b, i)));
    end
  end

  assign next_en = s_reg.keep | ({7{run}} & src) | off_hold;
  assign low_rail = s_reg.en_out & ~rail_ok_in;

  // =====================================================
  // state update
  always_comb begin
    s_next = s_reg;
    s_next.ms_div = tick ? 16'h0000 : s_reg.ms_div + 16'h0001;
    s_next.en_out = next_en;
    // supply rise watchdog
    if (supply_rise_ok_in) begin
      s_next.rise_seen = 1'b1;
      s_next.inhibit = 1'b0;
    end else if (!s_reg.rise_seen && tick) begin
      if (s_reg.rise_cnt == rsq_pkg::RISE_TIMEOUT_MS - 13'h0001) begin
        s_next.inhibit = 1'b1;
      end else begin
        s_next.rise_cnt = s_reg.rise_cnt + 13'h0001;
      end
    end
    // heat fault with hysteresis
    if (die_heat_fault) begin
      s_next.heat_flt = 1'b1;
    end else if (die_cool_in) begin
      s_next.heat_flt = 1'b0;
    end
    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        rsq_pkg::ADDR_MAIN_CTRL: s_next.ctrl = reg_req.wdata;
        rsq_pkg::ADDR_DOWN_A: s_next.down_a = reg_req.wdata;
        rsq_pkg::ADDR_DOWN_B: s_next.down_b = {2'h0, reg_req.wdata[5:0]};
        rsq_pkg::ADDR_RAIL_EN: s_next.rail_en = reg_req.wdata[6:0];
        rsq_pkg::ADDR_KEEP: s_next.keep = reg_req.wdata[6:0];
        default: s_next.ctrl = s_next.ctrl;
      endcase
    end
    // events: set wins over write-one clear
    s_next.evt = s_reg.evt;
    if (reg_req.wr && reg_req.addr == rsq_pkg::ADDR_EVENT) begin
      s_next.evt = s_reg.evt & ~reg_req.wdata[4:0];
    end
    if (supply_warn_in) s_next.evt[rsq_pkg::EVT_SUPPLY_WARN] = 1'b1;
    if (heat_warn_in) s_next.evt[rsq_pkg::EVT_HEAT_WARN] = 1'b1;
    if (|low_rail) s_next.evt[rsq_pkg::EVT_RAIL_LOW] = 1'b1;
    // operating mode
    case (s_reg.mode)
      rsq_pkg::MODE_POR, rsq_pkg::MODE_STANDBY: begin
        if (hold_req && !fault) begin
          s_next.mode = rsq_pkg::MODE_PWR_TIMER;
          s_next.tmr = 13'h0000;
        end
      end
      rsq_pkg::MODE_PWR_TIMER, rsq_pkg::MODE_ON: begin
        if (tick && s_reg.tmr != rsq_pkg::PWR_TIMER_MS) begin
          s_next.tmr = s_reg.tmr + 13'h0001;
        end
        if (fault || hrst_req_in || (s_reg.mode == rsq_pkg::MODE_ON && !hold_req) ||
            (s_reg.mode == rsq_pkg::MODE_PWR_TIMER && s_reg.tmr == rsq_pkg::PWR_TIMER_MS && !hold_req)) begin
          s_next.mode = hrst_req_in && !fault ? rsq_pkg::MODE_OFF_HRST : rsq_pkg::MODE_OFF_STBY;
          s_next.tmr = 13'h0000;
          s_next.ms_div = 16'h0000;
          s_next.was_on = {7{run}} & src;
          if (fault || hrst_req_in) begin
            s_next.keep = 7'h00;
          end
          if (supply_low_fault && s_reg.rise_seen) s_next.evt[rsq_pkg::EVT_SUPPLY_STBY] = 1'b1;
          if (s_reg.heat_flt) s_next.evt[rsq_pkg::EVT_HEAT_STBY] = 1'b1;
        end else if (s_reg.mode == rsq_pkg::MODE_PWR_TIMER && s_reg.tmr == rsq_pkg::PWR_TIMER_MS) begin
          s_next.mode = rsq_pkg::MODE_ON;
        end
      end
      rsq_pkg::MODE_OFF_STBY, rsq_pkg::MODE_OFF_HRST: begin
        s_next.rail_en = rsq_pkg::RAIL_RST;
        s_next.ctrl[rsq_pkg::CTRL_SW_MODE] = 1'b0;
        if (s_reg.mode == rsq_pkg::MODE_OFF_HRST) begin
          s_next.ctrl = rsq_pkg::CTRL_RST;
          s_next.down_a = rsq_pkg::DOWN_RST;
          s_next.down_b = rsq_pkg::DOWN_RST;
          s_next.keep = rsq_pkg::RAIL_RST;
        end
        if (tick) begin
          if (s_reg.tmr == rsq_pkg::OFF_TIME_MS - 13'h0001) begin
            s_next.mode = (s_reg.mode == rsq_pkg::MODE_OFF_HRST) ? rsq_pkg::MODE_POR : rsq_pkg::MODE_STANDBY;
            s_next.was_on = 7'h00;
          end
          s_next.tmr = s_reg.tmr + 13'h0001;
        end
      end
      default: s_next.mode = rsq_pkg::MODE_POR;
    endcase
    // read data, one cycle after the address
    case (reg_req.addr)
      rsq_pkg::ADDR_MAIN_CTRL: s_next.rdata = s_reg.ctrl;
      rsq_pkg::ADDR_DOWN_A: s_next.rdata = s_reg.down_a;
      rsq_pkg::ADDR_DOWN_B: s_next.rdata = s_reg.down_b;
      rsq_pkg::ADDR_RAIL_EN: s_next.rdata = {1'b0, s_reg.rail_en};
      rsq_pkg::ADDR_KEEP: s_next.rdata = {1'b0, s_reg.keep};
      rsq_pkg::ADDR_EVENT: s_next.rdata = {3'h0, s_reg.evt};
      rsq_pkg::ADDR_RAIL_VALID: s_next.rdata = {1'b0, ~low_rail};
      default: s_next.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.mode <= rsq_pkg::MODE_POR;
      s_reg.ctrl <= rsq_pkg::CTRL_RST;
      s_reg.down_a <= rsq_pkg::DOWN_RST;
      s_reg.down_b <= rsq_pkg::DOWN_RST;
      s_reg.evt <= rsq_pkg::EVT_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // =====================================================
  // outputs
  assign reg_rdata = s_reg.rdata;
  assign rail_en_out = s_reg.en_out;
  assign wake_out = (s_reg.mode == rsq_pkg::MODE_PWR_TIMER) || (s_reg.mode == rsq_pkg::MODE_ON);
  assign attn_req_n = ~(|s_reg.evt);
  assign rails_valid_pin_out = 1'b0;
  assign rails_valid_pin_oe = (s_reg.en_out == 7'h00) || (|low_rail);
  assign supply_warn_code = s_reg.ctrl[rsq_pkg::CTRL_SUPPLY_LSB +: 3];
  assign heat_warn_code = s_reg.ctrl[rsq_pkg::CTRL_HEAT_LSB +: 2];

  // =====================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sw_mode_clear_a: assert property (in_off |=> !s_reg.ctrl[rsq_pkg::CTRL_SW_MODE])
    else $error("software mode kept in off state");
  sw_mode_follow_a: assert property ((run && s_reg.ctrl[rsq_pkg::CTRL_SW_MODE])
    |=> rail_en_out == ($past(s_reg.rail_en) | $past(s_reg.keep)))
    else $error("rails not following register enables");
  keep_alive_a: assert property (s_reg.keep[0] |=> rail_en_out[0])
    else $error("keep-alive rail dropped");
  keep_clear_a: assert property ((s_reg.mode == rsq_pkg::MODE_ON && fault) |=> s_reg.keep == 7'h00)
    else $error("keep-alive survived fault shutdown");
  down_order_a_a: assert property ((in_off && !s_reg.keep[0]
    && s_reg.tmr >= hold_ms(s_reg.down_a[1:0])) |=> !rail_en_out[0])
    else $error("switcher one late to drop");
  down_order_b_a: assert property ((in_off && s_reg.was_on[4] && !s_reg.inhibit
    && s_reg.tmr < hold_ms(s_reg.down_b[1:0])) |=> rail_en_out[4])
    else $error("linear two dropped early");
  supply_fault_a: assert property ((s_reg.mode == rsq_pkg::MODE_ON && supply_low_fault
    && s_reg.rise_seen) |=> s_reg.mode == rsq_pkg::MODE_OFF_STBY)
    else $error("supply fault not taken");
  rise_inhibit_a: assert property ((s_reg.inhibit && s_reg.keep == 7'h00) |=> rail_en_out == 7'h00)
    else $error("rail enabled while inhibited");
  heat_hold_a: assert property ((s_reg.heat_flt && !die_cool_in) |=> s_reg.heat_flt)
    else $error("heat fault cleared too early");
  standby_off_a: assert property ((s_reg.mode == rsq_pkg::MODE_STANDBY && s_reg.keep == 7'h00)
    |=> rail_en_out == 7'h00)
    else $error("rail on in standby");
endmodule
`default_nettype wire

// ==== verif/rsq_far_model.sv ====
// Purpose: far side of the rail sequence and fault controller: host hold pin and rail outputs
// Assumes: rails reach regulation two core cycles after their enable
// Notes: a disabled rail reads not ok at once, with no hold-over
`default_nettype none
module rsq_far_model (
  input wire logic clk_sys,
  input wire logic [6:0] rail_en_out,
  input wire logic hold_req,
  input wire logic supply_good,
  output logic power_hold_in,
  output logic [6:0] rail_ok_in
);
  logic [6:0] ok_d1_reg;
  logic [6:0] ok_d2_reg;
  // =====================================================
  // host side
  // host raises power-hold only while its supply monitor says good
  assign power_hold_in = hold_req & supply_good;
  // =====================================================
  // rail outputs
  always_ff @(posedge clk_sys) begin
    ok_d1_reg <= rail_en_out;
    ok_d2_reg <= ok_d1_reg;
  end
  assign rail_ok_in = ok_d2_reg & rail_en_out;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: self-checking bench of the rail sequence and fault controller
// Assumes: shortened counts, 8 cycle pin delay and 10 cycle millisecond
// Notes: driver queues expectations, a watcher compares them after each falling edge
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int EN_DLY = 8;
  localparam int MS = 10;
  localparam logic [7:0] DOWN_A = 8'h67;
  localparam logic [7:0] DOWN_B = 8'h24;
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] exp;
  } rsq_tb_note_type;
  logic clk_sys;
  logic rst_n;
  logic hold_req;
  logic supply_good;
  logic power_hold_in;
  logic hrst_req_in;
  logic [6:0] en_pin_in;
  logic [6:0] rail_ok_in;
  logic supply_rise_ok_in;
  logic supply_low_fault;
  logic supply_warn_in;
  logic die_heat_fault;
  logic die_cool_in;
  logic heat_warn_in;
  rsq_pkg::rsq_reg_req_type reg_req;
  logic [7:0] reg_rdata;
  logic [6:0] rail_en_out;
  logic wake_out;
  logic attn_req_n;
  logic rails_valid_pin_out;
  logic rails_valid_pin_oe;
  logic [2:0] supply_warn_code;
  logic [1:0] heat_warn_code;
  wire logic rails_valid_wire;
  int errors = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int t0;
  logic [7:0] d;
  rsq_tb_note_type n;
  rsq_tb_note_type note_q[$];
  string names[6] = '{"reg_rdata", "rail_en_out", "wake_out", "attn_req_n", "warn_codes", "rails_valid_pin"};
  // open-drain pin with its pull-up
  assign rails_valid_wire = rails_valid_pin_oe ? rails_valid_pin_out : 1'b1;
  rsq_seq_ctrl #(.EN_DLY_CYC(EN_DLY), .MS_CYC(MS)) u_rsq_seq_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .power_hold_in(power_hold_in), .hrst_req_in(hrst_req_in),
    .en_pin_in(en_pin_in), .rail_ok_in(rail_ok_in), .supply_rise_ok_in(supply_rise_ok_in),
    .supply_low_fault(supply_low_fault), .supply_warn_in(supply_warn_in), .die_heat_fault(die_heat_fault),
    .die_cool_in(die_cool_in), .heat_warn_in(heat_warn_in), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rail_en_out(rail_en_out), .wake_out(wake_out), .attn_req_n(attn_req_n),
    .rails_valid_pin_out(rails_valid_pin_out), .rails_valid_pin_oe(rails_valid_pin_oe),
    .supply_warn_code(supply_warn_code), .heat_warn_code(heat_warn_code));
  rsq_far_model u_rsq_far_model (
    .clk_sys(clk_sys), .rail_en_out(rail_en_out), .hold_req(hold_req), .supply_good(supply_good),
    .power_hold_in(power_hold_in), .rail_ok_in(rail_ok_in));
  // =====================================================
  // helpers
  function automatic logic [7:0] got_val(input logic [2:0] sel);
    case (sel)
      3'h0: return reg_rdata;
      3'h1: return {1'b0, rail_en_out};
      3'h2: return {7'h00, wake_out};
      3'h3: return {7'h00, attn_req_n};
      3'h4: return {3'h0, supply_warn_code, heat_warn_code};
      default: return {7'h00, rails_valid_wire};
    endcase
  endfunction
  // rails still on k steps of 100 ms after wake falls
  function automatic logic [6:0] still_on(input int k);
    logic [13:0] codes;
    codes = {DOWN_B[5:0], DOWN_A};
    for (int r = 0; r < 7; r++) still_on[r] = int'(codes[2*r +: 2]) > k;
  endfunction
  task automatic expect_out(input logic [2:0] sel, input logic [7:0] exp);
    note_q.push_back('{sel, exp});
  endtask
  task automatic cycles(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic reg_wr(input logic [2:0] addr, input logic [7:0] data);
    reg_req = '{1'b1, addr, data};
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic reg_rd(input logic [2:0] addr, input logic [7:0] exp);
    reg_req = '{1'b0, addr, 8'h00};
    @(negedge clk_sys);
    expect_out(3'h0, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // =====================================================
  // clock, watcher, timeout
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    #1;
    while (note_q.size() > 0) begin
      n = note_q.pop_front();
      `CHK(names[n.sel], n.exp, got_val(n.sel))
    end
  end
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 70000) begin
      errors++;
      test_done();
    end
  end
  // =====================================================
  // stimulus
  initial begin
    rst_n = 1'b0;
    hold_req = 1'b0;
    supply_good = 1'b1;
    hrst_req_in = 1'b0;
    en_pin_in = 7'h00;
    supply_rise_ok_in = 1'b0;
    supply_low_fault = 1'b0;
    supply_warn_in = 1'b0;
    die_heat_fault = 1'b0;
    die_cool_in = 1'b0;
    heat_warn_in = 1'b0;
    reg_req = '0;
    t0 = $urandom(98);
    cycles(5);
    rst_n = 1'b1;
    for (int a = 0; a < 5; a++) begin
      reg_rd(3'(a), 8'h00);
    end
    reg_rd(3'h7, 8'h00);
    expect_out(3'h1, 8'h00);
    expect_out(3'h3, 8'h01);
    expect_out(3'h5, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom()) & 8'h1f;
      reg_wr(rsq_pkg::ADDR_MAIN_CTRL, d);
      expect_out(3'h4, d);
    end
    reg_wr(rsq_pkg::ADDR_MAIN_CTRL, 8'h00);
    expect_out(3'h4, 8'h00);
    en_pin_in = 7'h01;
    cycles(EN_DLY + 4);
    expect_out(3'h1, 8'h00);
    reg_wr(rsq_pkg::ADDR_KEEP, 8'h40);
    cycles(2);
    expect_out(3'h1, 8'h40);
    // power up before the supply rise is seen
    hold_req = 1'b1;
    en_pin_in = 7'h00;
    cycles(1);
    expect_out(3'h2, 8'h01);
    cycles(3);
    en_pin_in = 7'h01;
    cycles(EN_DLY);
    expect_out(3'h1, 8'h40);
    cycles(1);
    expect_out(3'h1, 8'h41);
    reg_wr(rsq_pkg::ADDR_RAIL_EN, 8'h06);
    reg_wr(rsq_pkg::ADDR_MAIN_CTRL, 8'h20);
    cycles(2);
    expect_out(3'h1, 8'h46);
    cycles(4);
    expect_out(3'h5, 8'h01);
    supply_rise_ok_in = 1'b1;
    cycles(5000 * MS + 200);
    reg_wr(rsq_pkg::ADDR_DOWN_A, DOWN_A);
    reg_wr(rsq_pkg::ADDR_DOWN_B, DOWN_B);
    reg_wr(rsq_pkg::ADDR_RAIL_EN, 8'h7f);
    reg_rd(rsq_pkg::ADDR_DOWN_A, DOWN_A);
    reg_rd(rsq_pkg::ADDR_DOWN_B, DOWN_B);
    expect_out(3'h1, 8'h7f);
    // supply fault from the on state, ordered shutdown
    supply_low_fault = 1'b1;
    t0 = cyc_cnt;
    cycles(2);
    expect_out(3'h2, 8'h00);
    expect_out(3'h3, 8'h00);
    supply_low_fault = 1'b0;
    reg_rd(rsq_pkg::ADDR_MAIN_CTRL, 8'h00);
    reg_rd(rsq_pkg::ADDR_KEEP, 8'h00);
    reg_rd(rsq_pkg::ADDR_RAIL_EN, 8'h00);
    hold_req = 1'b0;
    for (int k = 0; k < 4; k++) begin
      while (cyc_cnt < t0 + k * 100 * MS + 50 * MS) @(negedge clk_sys);
      expect_out(3'h1, {1'b0, still_on(k)});
    end
    while (cyc_cnt < t0 + 1000 * MS + 300) @(negedge clk_sys);
    expect_out(3'h1, 8'h00);
    en_pin_in = 7'h7f;
    cycles(EN_DLY + 4);
    expect_out(3'h1, 8'h00);
    // latched heat fault blocks power-up until the die cools
    en_pin_in = 7'h00;
    die_heat_fault = 1'b1;
    cycles(2);
    die_heat_fault = 1'b0;
    hold_req = 1'b1;
    cycles(20);
    expect_out(3'h2, 8'h00);
    die_cool_in = 1'b1;
    cycles(3);
    expect_out(3'h2, 8'h01);
    cycles(2);
    test_done();
  end
endmodule
`undef CHK
`default_nettype wire
